// [hdl/ims_master.sv]
// two-wire master sequencer: start, repeated start, stop, byte transmit/receive, acknowledge
// Operation
// - start enable with idle lines loads counter
// - timeout with lines high drives sda low
// - one more period, clear start enable
// - low lines or early scl low: collision
// - repeated start accepted only when idle
// - repeated start: scl low, release sda, release scl
// - sda low one period, then scl low
// - start flag on pins, interrupt after timeout
// - repeated start collision on sda or scl
// - buffer write sets full, starts transmission
// - bit after scl falls, low then high periods
// - eighth falling edge clears full, releases sda
// - ninth clock captures acknowledge into result
// - after ninth clock interrupt, hold scl low
// - write while shifting out sets write collision
// - receive enable ignored unless idle
// - receive toggles scl each rollover, shifts sda
// - eighth falling edge: buffer, full, interrupt
// - reading received buffer clears full flag
// - new byte while full sets overflow
// - write while shifting in sets write collision
// - released scl pauses counter until high
// - busy buffer write collides, control enables blocked
// - acknowledge sequence clocks out acknowledge value
`timescale 1ns/1ps
`include "ims_regs.svh"

module ims_master (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe
);

   ims_pkg::ims_state_t q;
   ims_pkg::ims_state_t n;
   logic                tmo;

   // drop every sequence, free both lines, flag the lost bus
   function automatic ims_pkg::ims_state_t abort_bus(input ims_pkg::ims_state_t s);
      ims_pkg::ims_state_t r;
      r        = s;
      r.state  = ims_pkg::ST_IDLE;
      r.scl_oe = 1'b0;
      r.sda_oe = 1'b0;
      r.start_enable_bit    = 1'b0;
      r.repeated_start_enable_bit   = 1'b0;
      r.stop_enable_bit    = 1'b0;
      r.receive_enable_bit   = 1'b0;
      r.acknowledge_sequence_enable_bit  = 1'b0;
      r.bcl    = 1'b1;
      if (s.mode == ims_pkg::MD_TX)
      begin
         r.bf = 1'b0;
      end
      return r;
   endfunction : abort_bus

   // load and start the bit-period counter
   function automatic ims_pkg::ims_state_t reload(input ims_pkg::ims_state_t s);
      ims_pkg::ims_state_t r;
      r     = s;
      r.cnt = s.div;
      return r;
   endfunction : reload

   always_comb
   begin
      n       = q;
      n.rdata = 8'h00;
      n.scl_m = scl_i;
      n.scl_s = q.scl_m;
      n.sda_m = sda_i;
      n.sda_s = q.sda_m;
      tmo     = (q.cnt == 8'h00);
      if (!tmo)
      begin
         n.cnt = q.cnt - 8'h01;
      end

      // register access first, so that flags set by the sequencer below win over a clear
      if (rd)
      begin
         case (addr)
            `IMS_ADDR_CTRL:
            begin
               n.rdata = {2'h0, q.acknowledge_value_bit, q.acknowledge_sequence_enable_bit, q.receive_enable_bit, q.stop_enable_bit, q.repeated_start_enable_bit, q.start_enable_bit};
            end
            `IMS_ADDR_STAT:
            begin
               n.rdata = {q.stop_det, q.start_det, q.bcl, q.intf, q.ackst, q.ovf, q.write_collision_flag, q.bf};
            end
            `IMS_ADDR_BUF:
            begin
               n.rdata = q.buf_r;
               if (q.rx_owned)
               begin
                  n.bf = 1'b0;
               end
            end
            default:
            begin
               n.rdata = q.div;
            end
         endcase
      end

      if (wr)
      begin
         case (addr)
            `IMS_ADDR_CTRL:
            begin
               n.acknowledge_value_bit = wdata[`IMS_CTRL_ACKNOWLEDGE_VALUE_BIT];
               // enables are only taken while nothing runs; one per write, start first
               if (q.state == ims_pkg::ST_IDLE)
               begin
                  if (wdata[`IMS_CTRL_SEN])
                  begin
                     if (q.scl_s && q.sda_s)
                     begin
                        n       = reload(n);
                        n.start_enable_bit   = 1'b1;
                        n.state = ims_pkg::ST_START1;
                     end
                     else
                     begin
                        n = abort_bus(n);
                     end
                  end
                  else if (wdata[`IMS_CTRL_REPEATED_START_ENABLE_BIT])
                  begin
                     n.repeated_start_enable_bit   = 1'b1;
                     n.scl_oe = 1'b1;
                     n.state  = ims_pkg::ST_RS1;
                  end
                  else if (wdata[`IMS_CTRL_PEN])
                  begin
                     n.stop_enable_bit    = 1'b1;
                     n.scl_oe = 1'b1;
                     n.sda_oe = 1'b1;
                     n        = reload(n);
                     n.state  = ims_pkg::ST_STOP1;
                  end
                  else if (wdata[`IMS_CTRL_RECEIVE_ENABLE_BIT])
                  begin
                     n.receive_enable_bit   = 1'b1;
                     n.mode   = ims_pkg::MD_RX;
                     n.bitcnt = 4'h0;
                     n.scl_oe = 1'b1;
                     n.sda_oe = 1'b0;
                     n        = reload(n);
                     n.state  = ims_pkg::ST_BLOW;
                  end
                  else if (wdata[`IMS_CTRL_ACKNOWLEDGE_SEQUENCE_ENABLE_BIT])
                  begin
                     n.acknowledge_sequence_enable_bit  = 1'b1;
                     n.mode   = ims_pkg::MD_ACK;
                     n.bitcnt = 4'h0;
                     n.scl_oe = 1'b1;
                     n.sda_oe = ~wdata[`IMS_CTRL_ACKNOWLEDGE_VALUE_BIT];
                     n        = reload(n);
                     n.state  = ims_pkg::ST_BLOW;
                  end
               end
            end
            `IMS_ADDR_STAT:
            begin
               // write one to clear; status bits that track the bus are read only
               if (wdata[`IMS_STAT_WRITE_COLLISION_FLAG])
               begin
                  n.write_collision_flag = 1'b0;
               end
               if (wdata[`IMS_STAT_OVF])
               begin
                  n.ovf = 1'b0;
               end
               if (wdata[`IMS_STAT_INT])
               begin
                  n.intf = 1'b0;
               end
               if (wdata[`IMS_STAT_BCL])
               begin
                  n.bcl = 1'b0;
               end
            end
            `IMS_ADDR_BUF:
            begin
               // a pending collision must be cleared first, so a stale write cannot launch a byte
               if (q.state != ims_pkg::ST_IDLE || q.write_collision_flag)
               begin
                  n.write_collision_flag = 1'b1;
               end
               else
               begin
                  n.buf_r    = wdata;
                  n.shreg    = wdata;
                  n.bf       = 1'b1;
                  n.rx_owned = 1'b0;
                  n.mode     = ims_pkg::MD_TX;
                  n.bitcnt   = 4'h0;
                  n.scl_oe   = 1'b1;
                  n.sda_oe   = ~wdata[7];
                  n          = reload(n);
                  n.state    = ims_pkg::ST_BLOW;
               end
            end
            default:
            begin
               n.div = wdata;
            end
         endcase
      end

      case (q.state)
         ims_pkg::ST_IDLE:
         begin
            // keep the reload made by a launching write above, else the first period is lost
            if (n.state == ims_pkg::ST_IDLE)
            begin
               n.cnt = q.cnt;
            end
         end
         ims_pkg::ST_START1:
         begin
            if (!q.scl_s)
            begin
               n = abort_bus(n);
            end
            else if (!q.sda_s || tmo)
            begin
               // sda pulled low by someone else: assert early and restart the count
               n.sda_oe = 1'b1;
               n        = reload(n);
               n.state  = ims_pkg::ST_START2;
            end
         end
         ims_pkg::ST_START2:
         begin
            if (!q.sda_s && q.scl_s)
            begin
               n.start_det = 1'b1;
               n.stop_det  = 1'b0;
            end
            if (tmo)
            begin
               n.start_enable_bit    = 1'b0;
               n.scl_oe = 1'b1;
               n.intf   = 1'b1;
               n.cnt    = q.cnt;
               n.state  = ims_pkg::ST_IDLE;
            end
         end
         ims_pkg::ST_RS1:
         begin
            n.cnt = q.cnt;
            if (!q.scl_s)
            begin
               n.sda_oe = 1'b0;
               n        = reload(n);
               n.state  = ims_pkg::ST_RS2;
            end
         end
         ims_pkg::ST_RS2:
         begin
            if (tmo)
            begin
               if (q.sda_s)
               begin
                  n.scl_oe = 1'b0;
                  n.state  = ims_pkg::ST_RS3;
               end
               else
               begin
                  n = reload(n);
               end
            end
         end
         ims_pkg::ST_RS3:
         begin
            n.cnt = q.cnt;
            if (q.scl_s)
            begin
               if (!q.sda_s)
               begin
                  n = abort_bus(n);
               end
               else
               begin
                  n       = reload(n);
                  n.state = ims_pkg::ST_RS4;
               end
            end
         end
         ims_pkg::ST_RS4:
         begin
            if (!q.scl_s || !q.sda_s)
            begin
               n = abort_bus(n);
            end
            else if (tmo)
            begin
               n.sda_oe = 1'b1;
               n        = reload(n);
               n.state  = ims_pkg::ST_RS5;
            end
         end
         ims_pkg::ST_RS5:
         begin
            if (!q.sda_s && q.scl_s)
            begin
               n.start_det = 1'b1;
               n.stop_det  = 1'b0;
            end
            if (tmo)
            begin
               n.scl_oe = 1'b1;
               n.repeated_start_enable_bit   = 1'b0;
               n.intf   = 1'b1;
               n.cnt    = q.cnt;
               n.state  = ims_pkg::ST_IDLE;
            end
         end
         ims_pkg::ST_BLOW:
         begin
            // data moves a cycle after scl falls, never on the same edge, to keep hold time
            if (q.mode == ims_pkg::MD_TX)
            begin
               n.sda_oe = (q.bitcnt != `IMS_BITS_ACK) && !q.shreg[7];
            end
            if (tmo)
            begin
               n.scl_oe = 1'b0;
               n.state  = ims_pkg::ST_BRISE;
            end
         end
         ims_pkg::ST_BRISE:
         begin
            n.cnt = q.cnt;
            if (q.scl_s)
            begin
               n       = reload(n);
               n.state = ims_pkg::ST_BHIGH;
               case (q.mode)
                  ims_pkg::MD_TX:
                  begin
                     if (q.bitcnt == `IMS_BITS_ACK)
                     begin
                        n.ackst = q.sda_s;
                     end
                     else if (q.shreg[7] && !q.sda_s)
                     begin
                        n = abort_bus(n);
                     end
                  end
                  ims_pkg::MD_RX:
                  begin
                     n.shreg = {q.shreg[6:0], q.sda_s};
                  end
                  default:
                  begin
                     n.shreg = q.shreg;
                  end
               endcase
            end
         end
         ims_pkg::ST_BHIGH:
         begin
            if (tmo)
            begin
               n.scl_oe = 1'b1;
               n.bitcnt = q.bitcnt + 4'h1;
               n        = reload(n);
               n.state  = ims_pkg::ST_BLOW;
               case (q.mode)
                  ims_pkg::MD_TX:
                  begin
                     if (q.bitcnt == `IMS_BITS_BYTE)
                     begin
                        n.bf     = 1'b0;
                     end
                     else if (q.bitcnt == `IMS_BITS_ACK)
                     begin
                        // sda left as it was; scl stays low until the next byte
                        n.intf  = 1'b1;
                        n.cnt   = q.cnt;
                        n.state = ims_pkg::ST_IDLE;
                     end
                     else
                     begin
                        n.shreg  = {q.shreg[6:0], 1'b0};
                     end
                  end
                  ims_pkg::MD_RX:
                  begin
                     if (q.bitcnt == `IMS_BITS_BYTE)
                     begin
                        n.receive_enable_bit  = 1'b0;
                        n.intf  = 1'b1;
                        n.cnt   = q.cnt;
                        n.state = ims_pkg::ST_IDLE;
                        // an unread byte is kept; the new one is dropped
                        if (q.bf)
                        begin
                           n.ovf = 1'b1;
                        end
                        else
                        begin
                           n.buf_r    = q.shreg;
                           n.bf       = 1'b1;
                           n.rx_owned = 1'b1;
                        end
                     end
                  end
                  default:
                  begin
                     n.acknowledge_sequence_enable_bit = 1'b0;
                     n.intf  = 1'b1;
                     n.cnt   = q.cnt;
                     n.state = ims_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         ims_pkg::ST_STOP1:
         begin
            // count only once sda is seen low
            if (q.sda_s)
            begin
               n = reload(n);
            end
            else if (tmo)
            begin
               n.scl_oe = 1'b0;
               n.state  = ims_pkg::ST_STOP2;
            end
         end
         ims_pkg::ST_STOP2:
         begin
            n.cnt = q.cnt;
            if (q.scl_s)
            begin
               n       = reload(n);
               n.state = ims_pkg::ST_STOP3;
            end
         end
         ims_pkg::ST_STOP3:
         begin
            if (tmo)
            begin
               n.sda_oe = 1'b0;
               n        = reload(n);
               n.state  = ims_pkg::ST_STOP4;
            end
         end
         ims_pkg::ST_STOP4:
         begin
            if (q.sda_s && q.scl_s)
            begin
               n.stop_det  = 1'b1;
               n.start_det = 1'b0;
            end
            if (tmo)
            begin
               n.stop_enable_bit   = 1'b0;
               n.intf  = 1'b1;
               n.cnt   = q.cnt;
               n.state = ims_pkg::ST_IDLE;
            end
         end
         default:
         begin
            n.state = ims_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         q       <= '0;
         q.scl_m <= 1'b1;
         q.scl_s <= 1'b1;
         q.sda_m <= 1'b1;
         q.sda_s <= 1'b1;
         q.state <= ims_pkg::ST_IDLE;
         q.mode  <= ims_pkg::MD_TX;
         q.div   <= `IMS_DIV_RESET;
      end
      else
      begin
         q <= n;
      end
   end

   assign rdata  = q.rdata;
   assign scl_oe = q.scl_oe;
   assign sda_oe = q.sda_oe;
   // open drain: the level driven is always low
   assign scl_o  = 1'b0;
   assign sda_o  = 1'b0;

endmodule : ims_master

// [shared/ims_regs.svh]
// register offsets, field positions and reset values of the two-wire master sequencer
`ifndef IMS_REGS_SVH
`define IMS_REGS_SVH

`define IMS_ADDR_CTRL    2'h0
`define IMS_ADDR_STAT    2'h1
`define IMS_ADDR_BUF     2'h2
`define IMS_ADDR_DIV     2'h3

// master_control_register fields
`define IMS_CTRL_SEN     0
`define IMS_CTRL_REPEATED_START_ENABLE_BIT    1
`define IMS_CTRL_PEN     2
`define IMS_CTRL_RECEIVE_ENABLE_BIT    3
`define IMS_CTRL_ACKNOWLEDGE_SEQUENCE_ENABLE_BIT   4
`define IMS_CTRL_ACKNOWLEDGE_VALUE_BIT   5

// port_status_register fields
`define IMS_STAT_BF      0
`define IMS_STAT_WRITE_COLLISION_FLAG    1
`define IMS_STAT_OVF     2
`define IMS_STAT_ACKST   3
`define IMS_STAT_INT     4
`define IMS_STAT_BCL     5
`define IMS_STAT_START   6
`define IMS_STAT_STOP    7

`define IMS_DIV_RESET    8'h00
`define IMS_BITS_BYTE    4'h7
`define IMS_BITS_ACK     4'h8

`endif

// [shared/ims_pkg.sv]
// types of the two-wire master sequencer
package ims_pkg;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_START1 = 4'h1,
      ST_START2 = 4'h3,
      ST_BLOW   = 4'h2,
      ST_BRISE  = 4'h6,
      ST_BHIGH  = 4'h7,
      ST_RS1    = 4'h5,
      ST_RS2    = 4'h4,
      ST_RS3    = 4'hc,
      ST_RS4    = 4'hd,
      ST_RS5    = 4'hf,
      ST_STOP1  = 4'he,
      ST_STOP2  = 4'ha,
      ST_STOP3  = 4'hb,
      ST_STOP4  = 4'h9
   } ims_fsm_t;

   typedef enum logic [1:0] {
      MD_TX  = 2'h0,
      MD_RX  = 2'h1,
      MD_ACK = 2'h2
   } ims_mode_t;

   typedef struct packed {
      logic       scl_m;
      logic       scl_s;
      logic       sda_m;
      logic       sda_s;
      ims_fsm_t   state;
      ims_mode_t  mode;
      logic [3:0] bitcnt;
      logic [7:0] cnt;
      logic [7:0] div;
      logic [7:0] buf_r;
      logic [7:0] shreg;
      logic       start_enable_bit;
      logic       repeated_start_enable_bit;
      logic       stop_enable_bit;
      logic       receive_enable_bit;
      logic       acknowledge_sequence_enable_bit;
      logic       acknowledge_value_bit;
      logic       bf;
      logic       write_collision_flag;
      logic       ovf;
      logic       ackst;
      logic       intf;
      logic       bcl;
      logic       start_det;
      logic       stop_det;
      logic       rx_owned;
      logic       scl_oe;
      logic       sda_oe;
      logic [7:0] rdata;
   } ims_state_t;

endpackage : ims_pkg

// [testbench/ims_master_properties.sv]
// port assertions of the two-wire master sequencer
`timescale 1ns/1ps
`include "ims_regs.svh"
module ims_master_properties (
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       scl_i,
   input wire logic       scl_o,
   input wire logic       scl_oe,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   logic go;
   // a start request seen with both lines released by us
   assign go = wr && addr == `IMS_ADDR_CTRL && wdata[`IMS_CTRL_SEN] && !scl_oe && !sda_oe;
   AST_START_WAIT: assert property (go && scl_i && sda_i |=> !sda_oe ##[1:300] sda_oe)
      else $error("start edge not produced after one bit period");
   AST_START_EDGE: assert property ($rose(sda_oe) && !scl_oe |-> scl_i)
      else $error("start edge made while clock low");
   AST_START_HOLD: assert property ($rose(sda_oe) && !scl_oe |=> !scl_oe ##[0:600] scl_oe)
      else $error("clock not pulled low after start edge");
   AST_BUS_COLL: assert property (go && !scl_i && !sda_i |=> !sda_oe [*8])
      else $error("start driven on a busy bus");
   AST_BIT_LOW: assert property ($rose(sda_oe) && $past(scl_oe) |-> scl_oe)
      else $error("data changed while clock released");
   AST_BIT_SETUP: assert property ($changed(sda_oe) && scl_oe |-> $past(scl_oe))
      else $error("data changed on the edge at which the clock fell");
   AST_STRETCH: assert property ($rose(scl_i) && !scl_oe |-> !scl_oe [*3])
      else $error("clock high time cut short");
   AST_RD_BF: assert property (rd && addr == `IMS_ADDR_BUF ##2 rd && addr == `IMS_ADDR_STAT
      |=> !rdata[`IMS_STAT_BF])
      else $error("buffer read left full flag set");
   AST_W1C: assert property (wr && addr == `IMS_ADDR_STAT && wdata[`IMS_STAT_INT] ##2 rd && addr == `IMS_ADDR_STAT
      |=> !rdata[`IMS_STAT_INT])
      else $error("interrupt flag not cleared");
endmodule : ims_master_properties
bind ims_master ims_master_properties u_prop (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe(sda_oe));

// [testbench/ims_slave_model.sv]
// behavioural target device on the two-wire bus
`timescale 1ns/1ps
module ims_slave_model (
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       rx,
   input  wire logic       ack_n,
   input  wire logic [7:0] dat,
   input  wire logic       jam,
   input  wire logic       hold,
   output logic            scl_oe,
   output logic            sda_oe
);
   logic [3:0] cnt = 4'hf;
   // the fall that ends a start opens bit 0, so count from minus one
   always @(negedge sda) if (scl) cnt = 4'hf;
   always @(negedge scl) cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
   assign scl_oe = hold;
   // released slots float to the pull-up, never the last level
   assign sda_oe = jam | (cnt < 4'h8 ? rx & ~dat[3'h7 - cnt[2:0]] : (cnt == 4'h8) & ~rx & ~ack_n);
endmodule : ims_slave_model

// [testbench/ims_master_tb.sv]
// self-checking bench of the two-wire master sequencer
`timescale 1ns/1ps
`include "ims_regs.svh"
module ims_master_tb;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [7:0] rdata;
   logic       scl_o, scl_oe, sda_o, sda_oe, s_scl_oe, s_sda_oe;
   logic       rx = 1'b0;
   logic       ack_n = 1'b0;
   logic [7:0] dat = 8'h00;
   logic       jam = 1'b0;
   logic       hold = 1'b0;
   logic [8:0] mon = 9'h000;
   int         nst = 0;
   int         errors = 0;
   int         n_tests = 0;
   wire        scl = ~(scl_oe | s_scl_oe);
   wire        sda = ~(sda_oe | s_sda_oe);
   always #2 clk = ~clk;
   always @(posedge scl) mon <= {mon[7:0], sda};
   always @(negedge sda) if (scl) nst++;
   ims_master i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
   ims_slave_model i_slv (.scl(scl), .sda(sda), .rx(rx), .ack_n(ack_n), .dat(dat), .jam(jam), .hold(hold),
      .scl_oe(s_scl_oe), .sda_oe(s_sda_oe));
   task automatic give_verdict;
      $display("Checks %0d, errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [1:0] a, output logic [7:0] d);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg
   // polls for the interrupt, hands back the status and clears the flag
   task automatic wait_int(output logic [7:0] s);
      logic [7:0] t;
      int         n = 0;
      s = 8'h00;
      while (s[`IMS_STAT_INT] !== 1'b1 && n < 3000)
      begin
         rreg(`IMS_ADDR_STAT, s);
         n++;
      end
      chk(s & 8'h10, 8'h10);
      wreg(`IMS_ADDR_STAT, 8'h10);
      rreg(`IMS_ADDR_STAT, t);
      chk(t & 8'h10, 8'h00);
   endtask : wait_int
   task automatic t_start;
      logic [7:0] s;
      wreg(`IMS_ADDR_DIV, 8'h07);
      wreg(`IMS_ADDR_CTRL, 8'h01);
      wreg(`IMS_ADDR_BUF, 8'h00);
      wait_int(s);
      chk(s & 8'h42, 8'h42);
      wreg(`IMS_ADDR_STAT, 8'h02);
      rreg(`IMS_ADDR_CTRL, s);
      chk(s, 8'h00);
      chk({6'h0, scl_oe, sda_oe}, 8'h03);
      chk({6'h0, scl_o, sda_o}, 8'h00);
   endtask : t_start
   // h stretches the first low phase from the far side
   task automatic t_tx(input logic [7:0] b, input logic an, input logic h);
      logic [7:0] s;
      int         n;
      n = nst;
      ack_n = an;
      wreg(`IMS_ADDR_BUF, b);
      hold <= h;
      rreg(`IMS_ADDR_STAT, s);
      chk(s & 8'h01, 8'h01);
      wreg(`IMS_ADDR_BUF, ~b);
      wreg(`IMS_ADDR_CTRL, 8'h02);
      wreg(`IMS_ADDR_CTRL, 8'h08);
      repeat (30) @(posedge clk);
      hold <= 1'b0;
      wait_int(s);
      chk(s & 8'h0f, {4'h0, an, 3'h2});
      chk(mon[8:1], b);
      chk({7'h0, scl_oe}, 8'h01);
      wreg(`IMS_ADDR_STAT, 8'h02);
      rreg(`IMS_ADDR_CTRL, s);
      chk(s, 8'h00);
      chk(8'(nst - n), 8'h00);
   endtask : t_tx
   task automatic t_rs;
      logic [7:0] s;
      int         n;
      n = nst;
      wreg(`IMS_ADDR_CTRL, 8'h02);
      wait_int(s);
      chk(s & 8'h40, 8'h40);
      chk(8'(nst - n), 8'h01);
      chk({7'h0, sda_oe}, 8'h01);
   endtask : t_rs
   task automatic t_rx(input logic [7:0] d, input logic an, input logic ov);
      logic [7:0] s;
      rx  = 1'b1;
      dat = d;
      wreg(`IMS_ADDR_CTRL, 8'h08);
      wreg(`IMS_ADDR_BUF, 8'h11);
      wait_int(s);
      chk(s & 8'h07, {5'h0, ov, 2'h3});
      rreg(`IMS_ADDR_CTRL, s);
      chk(s & 8'h08, 8'h00);
      wreg(`IMS_ADDR_STAT, 8'h06);
      wreg(`IMS_ADDR_CTRL, {2'h0, an, 5'h10});
      wait_int(s);
      chk(mon[8:1], d);
      chk({7'h0, mon[0]}, {7'h0, an});
   endtask : t_rx
   task automatic t_bcl;
      logic [7:0] s;
      @(posedge clk);
      jam  <= 1'b1;
      hold <= 1'b1;
      repeat (4) @(posedge clk);
      wreg(`IMS_ADDR_CTRL, 8'h01);
      repeat (20) @(posedge clk);
      rreg(`IMS_ADDR_STAT, s);
      chk(s & 8'h20, 8'h20);
      chk({7'h0, sda_oe}, 8'h00);
      jam  <= 1'b0;
      hold <= 1'b0;
      wreg(`IMS_ADDR_STAT, 8'h30);
      rreg(`IMS_ADDR_STAT, s);
      chk(s & 8'h30, 8'h00);
   endtask : t_bcl
   initial
   begin
      logic [7:0] s;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 4; i++)
      begin
         rreg(2'(i), s);
         chk(s, 8'h00);
      end
      t_start;
      t_tx(8'ha5, 1'b0, 1'b1);
      t_tx(8'h3c, 1'b1, 1'b0);
      t_rs;
      t_tx(8'h81, 1'b0, 1'b0);
      t_rx(8'h96, 1'b0, 1'b0);
      t_rx(8'h5a, 1'b1, 1'b1);
      rreg(`IMS_ADDR_BUF, s);
      chk(s, 8'h96);
      rreg(`IMS_ADDR_STAT, s);
      chk(s & 8'h01, 8'h00);
      rx = 1'b0;
      wreg(`IMS_ADDR_CTRL, 8'h04);
      wait_int(s);
      chk({6'h0, scl_oe, sda_oe}, 8'h00);
      t_bcl;
      give_verdict;
   end
   initial
   begin
      #300000;
      errors++;
      give_verdict;
   end
endmodule : ims_master_tb
